// ### rtl/dram_cmd_ctrl.sv
// controller driving the command, bank and address pins of a multi-bank dram
// assumes pins are sampled by the memory on rising ref_clk edges and that
// software issues one command at a time through the axi4-lite registers
//
// Operation
// - only the four defined commands or deselect ever appear on the pins
// - we_n/ref_n low-low mode set, high-high read, low-high write, high-low refresh
// - refresh hits only the chosen bank; address unused; one per refresh
// - mode set carries address 0..17; bits 10..17 zero; bit 6 unused
// - mode set only while all banks idle and nothing in progress
// - wait recovery after mode set, except back-to-back mode sets
// - burst of eight with configuration one or four is never programmed
// - config four: write then read same bank needs four cycles
// - used address width drops one bit per burst doubling and part width
// - multiplexed mode sends the address in two halves on two edges
// - deselect is driven in idle and wait cycles; running work unaffected
// - after dll bit set high wait 1024 cycles before any read
// - multiplexed refresh needs one cycle, so refreshes may follow back to back
`timescale 1ns/1ps
`default_nettype none
module dram_cmd_ctrl #(
	parameter int DQ_WIDTH    = 9,
	parameter int MRS_RECOVER = dram_cmd_pkg::MRS_RECOVER_CYC,
	parameter int DLL_LOCK    = dram_cmd_pkg::DLL_LOCK_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// memory command pins
	output logic             mem_select_n,
	output logic             mem_we_n,
	output logic             mem_ref_n,
	output logic [20:0]      mem_addr,
	output logic [2:0]       mem_bank_select_bits
);
	typedef enum logic {ST_IDLE, ST_SECOND} issue_state_t;

	localparam logic [1:0] WSEL = (DQ_WIDTH == 36) ? 2'h2 :
		(DQ_WIDTH == 18) ? 2'h1 : 2'h0;
	localparam logic [7:0]  REC_LOAD = 8'(MRS_RECOVER - 1);
	localparam logic [10:0] DLL_LOAD = 11'(DLL_LOCK - 1);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// row cycle, which also equals the read latency
	function automatic logic [3:0] row_cycle_time(input logic [2:0] cfg);
		case (cfg)
			3'h2:    row_cycle_time = 4'h6;
			3'h3:    row_cycle_time = 4'h8;
			3'h4:    row_cycle_time = 4'h3;
			3'h5:    row_cycle_time = 4'h5;
			default: row_cycle_time = 4'h4;
		endcase
	endfunction

	function automatic logic [3:0] burst_clocks(input logic [1:0] bs);
		case (bs)
			dram_cmd_pkg::BL_4: burst_clocks = 4'h2;
			dram_cmd_pkg::BL_8: burst_clocks = 4'h4;
			default:            burst_clocks = 4'h1;
		endcase
	endfunction

	// address bits beyond the used width are driven low
	function automatic logic [20:0] addr_mask(input logic [1:0] bs);
		logic [4:0] top;
		top = 5'h14 - {3'h0, bs} - {3'h0, WSEL};
		for (int i = 0; i < dram_cmd_pkg::ADDR_PINS; i++) begin
			addr_mask[i] = (5'(i) <= top);
		end
	endfunction

	function automatic logic bad_mode(input logic [17:0] m);
		logic [2:0] cfg;
		cfg = m[dram_cmd_pkg::MODE_CFG_LSB +: 3];
		bad_mode = (cfg == 3'h0) || (cfg > 3'h5) ||
			(m[dram_cmd_pkg::MODE_BL_LSB +: 2] == 2'h3) ||
			((m[dram_cmd_pkg::MODE_BL_LSB +: 2] == dram_cmd_pkg::BL_8) &&
			((cfg == 3'h1) || (cfg == 3'h4)));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	issue_state_t st_ff;
	logic        pend_ff;
	logic [1:0]  pcmd_ff;
	logic [20:0] addr_ff;
	logic [2:0]  bank_ff;
	logic [17:0] mode_ff;
	logic        refused_ff;
	logic        bad_ff;
	logic [7:0]  rec_cnt_ff;
	logic [3:0]  row_cnt_ff;
	logic        wr_extra_ff;
	logic [2:0]  last_bank_ff;
	logic [4:0]  act_cnt_ff;
	logic [10:0] dll_cnt_ff;
	logic [9:0]  hi_addr_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;

	logic [2:0]  cfg;
	logic [1:0]  bs;
	logic        mux;
	logic        busy;
	logic        go;
	logic        same_bank;
	logic        ok_mode;
	logic        ok_other;
	logic        wr_go;
	logic        rd_go;
	logic        cmd_wr;
	logic        stat_wr;
	logic [20:0] used_addr;

	assign cfg  = mode_ff[dram_cmd_pkg::MODE_CFG_LSB +: 3];
	// a burst change leaves older data unreliable; software must rewrite it
	assign bs   = mode_ff[dram_cmd_pkg::MODE_BL_LSB +: 2];
	// both address halves carry only the bits the burst length and part width leave in use
	assign used_addr = addr_ff & addr_mask(bs);
	assign mux  = mode_ff[dram_cmd_pkg::MODE_MUX_BIT];
	assign busy = pend_ff || (st_ff != ST_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign rd_go = s_axi_arvalid && !rvalid_ff;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = dram_cmd_pkg::RESP_OKAY;
	assign cmd_wr  = wr_go && (s_axi_awaddr == dram_cmd_pkg::OFF_CMD) &&
		(s_axi_wstrb != 4'h0);
	assign stat_wr = wr_go && (s_axi_awaddr == dram_cmd_pkg::OFF_STATUS);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= dram_cmd_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			case (s_axi_awaddr)
				dram_cmd_pkg::OFF_CMD, dram_cmd_pkg::OFF_ADDR,
				dram_cmd_pkg::OFF_BANK, dram_cmd_pkg::OFF_STATUS,
				dram_cmd_pkg::OFF_MODE: bresp_ff <= dram_cmd_pkg::RESP_OKAY;
				default: bresp_ff <= dram_cmd_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			case (s_axi_araddr)
				dram_cmd_pkg::OFF_CMD:    rdata_ff <= {30'h0, pcmd_ff};
				dram_cmd_pkg::OFF_ADDR:   rdata_ff <= {11'h0, addr_ff};
				dram_cmd_pkg::OFF_BANK:   rdata_ff <= {29'h0, bank_ff};
				dram_cmd_pkg::OFF_STATUS: rdata_ff <= {27'h0, rec_cnt_ff != 8'h0,
					bad_ff, refused_ff, dll_cnt_ff != 11'h0, busy};
				dram_cmd_pkg::OFF_MODE:   rdata_ff <= {14'h0, mode_ff};
				default:                  rdata_ff <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// address and bank are plain holding registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= 21'h000000;
			bank_ff <= 3'h0;
		end else begin
			if (wr_go && (s_axi_awaddr == dram_cmd_pkg::OFF_ADDR))
				addr_ff <= s_axi_wdata[20:0];
			if (wr_go && (s_axi_awaddr == dram_cmd_pkg::OFF_BANK))
				bank_ff <= s_axi_wdata[2:0];
		end
	end

	// a command is refused while another is pending or in its second half, and a mode word
	// that is unsupported never reaches the pins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff    <= 1'b0;
			pcmd_ff    <= dram_cmd_pkg::CMD_MODE;
			refused_ff <= 1'b0;
			bad_ff     <= 1'b0;
		end else begin
			if (go)
				pend_ff <= 1'b0;
			if (cmd_wr && busy) begin
				refused_ff <= 1'b1;
			end else if (cmd_wr && (s_axi_wdata[1:0] == dram_cmd_pkg::CMD_MODE) &&
				bad_mode(addr_ff[17:0])) begin
				bad_ff <= 1'b1;
			end else if (cmd_wr) begin
				pend_ff <= 1'b1;
				pcmd_ff <= s_axi_wdata[1:0];
			end
			// refused set wins over its write-one clear; the bad mode clear wins over its set
			if (stat_wr && s_axi_wdata[dram_cmd_pkg::ST_REFUSED] &&
				!(cmd_wr && busy))
				refused_ff <= 1'b0;
			if (stat_wr && s_axi_wdata[dram_cmd_pkg::ST_BADMODE])
				bad_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// issue gating

	assign same_bank = (bank_ff == last_bank_ff);
	assign ok_mode   = (act_cnt_ff == 5'h0) && (row_cnt_ff == 4'h0);
	// back-to-back mode sets skip the recovery wait
	assign ok_other  = (rec_cnt_ff == 8'h0) &&
		!(same_bank && (row_cnt_ff != 4'h0)) &&
		!(same_bank && wr_extra_ff &&
		(pcmd_ff == dram_cmd_pkg::CMD_READ)) &&
		!((pcmd_ff == dram_cmd_pkg::CMD_READ) && (dll_cnt_ff != 11'h0));
	assign go = pend_ff && (st_ff == ST_IDLE) &&
		((pcmd_ff == dram_cmd_pkg::CMD_MODE) ? ok_mode : ok_other);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_cnt_ff   <= 4'h0;
			wr_extra_ff  <= 1'b0;
			last_bank_ff <= 3'h0;
		end else if (go && (pcmd_ff != dram_cmd_pkg::CMD_MODE)) begin
			row_cnt_ff   <= row_cycle_time(cfg) - 4'h1;
			wr_extra_ff  <= (pcmd_ff == dram_cmd_pkg::CMD_WRITE) &&
				(cfg == 3'h4);
			last_bank_ff <= bank_ff;
		end else if (row_cnt_ff != 4'h0) begin
			row_cnt_ff <= row_cnt_ff - 4'h1;
		end else begin
			wr_extra_ff <= 1'b0;
		end
	end

	// conservative end of a burst: latency plus data clocks plus one spare
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_cnt_ff <= 5'h00;
		end else if (go && ((pcmd_ff == dram_cmd_pkg::CMD_READ) ||
			(pcmd_ff == dram_cmd_pkg::CMD_WRITE))) begin
			act_cnt_ff <= {1'b0, row_cycle_time(cfg)} + 5'h1 +
				{1'b0, burst_clocks(bs)};
		end else if (go && (pcmd_ff == dram_cmd_pkg::CMD_REFRESH)) begin
			act_cnt_ff <= {1'b0, row_cycle_time(cfg)};
		end else if (act_cnt_ff != 5'h00) begin
			act_cnt_ff <= act_cnt_ff - 5'h01;
		end
	end

	// mode shadow, recovery and dll lock timers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff    <= dram_cmd_pkg::MODE_RESET;
			rec_cnt_ff <= 8'h00;
			dll_cnt_ff <= 11'h000;
		end else begin
			if (rec_cnt_ff != 8'h00)
				rec_cnt_ff <= rec_cnt_ff - 8'h01;
			if (dll_cnt_ff != 11'h000)
				dll_cnt_ff <= dll_cnt_ff - 11'h001;
			if (go && (pcmd_ff == dram_cmd_pkg::CMD_MODE)) begin
				mode_ff    <= {8'h00, addr_ff[9:0]};
				rec_cnt_ff <= REC_LOAD;
				if (addr_ff[dram_cmd_pkg::MODE_DLL_BIT] &&
					!mode_ff[dram_cmd_pkg::MODE_DLL_BIT])
					dll_cnt_ff <= DLL_LOAD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drive

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff                <= ST_IDLE;
			mem_select_n         <= 1'b1;
			mem_we_n             <= 1'b1;
			mem_ref_n            <= 1'b1;
			mem_addr             <= 21'h000000;
			mem_bank_select_bits <= 3'h0;
			hi_addr_ff           <= 10'h000;
		end else if (go) begin
			mem_select_n         <= 1'b0;
			{mem_we_n, mem_ref_n} <= pcmd_ff;
			mem_bank_select_bits <= bank_ff;
			// a mode set has no upper half, so its second cycle drives zero
			hi_addr_ff           <= (pcmd_ff == dram_cmd_pkg::CMD_MODE) ?
				10'h000 : used_addr[20:11];
			if (pcmd_ff == dram_cmd_pkg::CMD_REFRESH) begin
				mem_addr <= 21'h000000;
			end else if (pcmd_ff == dram_cmd_pkg::CMD_MODE) begin
				mem_addr <= {11'h000, addr_ff[9:0]};
			end else if (mux) begin
				mem_addr <= {10'h000, used_addr[10:0]};
			end else begin
				mem_addr <= used_addr;
			end
			if (mux && (pcmd_ff != dram_cmd_pkg::CMD_REFRESH))
				st_ff <= ST_SECOND;
		end else if (st_ff == ST_SECOND) begin
			mem_select_n <= 1'b1;
			mem_we_n     <= 1'b1;
			mem_ref_n    <= 1'b1;
			mem_addr     <= {11'h000, hi_addr_ff};
			st_ff        <= ST_IDLE;
		end else begin
			mem_select_n <= 1'b1;
			mem_we_n     <= 1'b1;
			mem_ref_n    <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [7:0]  since_mrs_ff;
	logic [10:0] since_dll_ff;
	logic        on_pins;
	logic [1:0]  pin_cmd;
	assign on_pins = !mem_select_n;
	assign pin_cmd = {mem_we_n, mem_ref_n};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_mrs_ff <= 8'hFF;
			since_dll_ff <= 11'h7FF;
		end else begin
			if (on_pins && (pin_cmd == dram_cmd_pkg::CMD_MODE))
				since_mrs_ff <= 8'h01;
			else if (since_mrs_ff != 8'hFF)
				since_mrs_ff <= since_mrs_ff + 8'h01;
			if (on_pins && (pin_cmd == dram_cmd_pkg::CMD_MODE) &&
				mem_addr[dram_cmd_pkg::MODE_DLL_BIT] && (dll_cnt_ff != 11'h0))
				since_dll_ff <= 11'h001;
			else if (since_dll_ff != 11'h7FF)
				since_dll_ff <= since_dll_ff + 11'h001;
		end
	end

	sequence mux_first_s;
		on_pins && mux && (pin_cmd != dram_cmd_pkg::CMD_REFRESH) &&
			(pin_cmd != dram_cmd_pkg::CMD_MODE);
	endsequence
	sequence mux_second_s;
		mem_select_n && (mem_addr[20:10] == 11'h000);
	endsequence

	idle_deselect_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!go && st_ff == ST_IDLE) |=> mem_select_n)
		else $error("pins not deselected while idle");
	mode_high_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd == dram_cmd_pkg::CMD_MODE) |-> mem_addr[20:10] == 0)
		else $error("mode set drove upper address bits");
	recover_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd != dram_cmd_pkg::CMD_MODE) |->
		since_mrs_ff >= 8'(MRS_RECOVER))
		else $error("command inside mode set recovery");
	dll_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd == dram_cmd_pkg::CMD_READ) |->
		since_dll_ff >= 11'(DLL_LOCK))
		else $error("read before dll lock time");
	combo_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd == dram_cmd_pkg::CMD_MODE) |=> !bad_mode(mode_ff))
		else $error("unsupported mode word programmed");
	mux_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mux_first_s |=> mux_second_s)
		else $error("second address half missing");
	refresh_single_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd == dram_cmd_pkg::CMD_REFRESH) |->
		mem_addr == 21'h0 ##1 st_ff == ST_IDLE)
		else $error("refresh took a second cycle or an address");
	wr_rd_bank_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd == dram_cmd_pkg::CMD_READ && cfg == 3'h4 &&
		$past(on_pins && pin_cmd == dram_cmd_pkg::CMD_WRITE, 3)) |->
		mem_bank_select_bits != $past(mem_bank_select_bits, 3))
		else $error("read too soon after write to same bank");
	mode_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && pin_cmd == dram_cmd_pkg::CMD_MODE) |->
		!$past(on_pins && pin_cmd != dram_cmd_pkg::CMD_MODE))
		else $error("mode set while an access is in progress");
	addr_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(on_pins && !mux && (pin_cmd == dram_cmd_pkg::CMD_READ ||
		pin_cmd == dram_cmd_pkg::CMD_WRITE)) |->
		(mem_addr & ~addr_mask(bs)) == 21'h0)
		else $error("address above used width");
endmodule
`default_nettype wire

// ### rtl/dram_cmd_pkg.sv
// constants for the multi-bank dram command controller
// assumes one 200 MHz clock; software reaches registers over axi4-lite
package dram_cmd_pkg;
	// clock and timing
	localparam int CLK_MHZ          = 200;
	localparam int DLL_LOCK_CYCLES  = 1024;
	localparam int MRS_RECOVER_CYC  = 6;
	// register byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_ADDR   = 8'h04;
	localparam logic [7:0] OFF_BANK   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_MODE   = 8'h10;
	// status bit positions
	localparam int ST_BUSY    = 0;
	localparam int ST_DLLWAIT = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_BADMODE = 3;
	localparam int ST_RECOVER = 4;
	// command codes equal the {we_n, ref_n} pin pair
	localparam logic [1:0] CMD_MODE    = 2'h0;
	localparam logic [1:0] CMD_WRITE   = 2'h1;
	localparam logic [1:0] CMD_REFRESH = 2'h2;
	localparam logic [1:0] CMD_READ    = 2'h3;
	// mode word fields
	localparam int MODE_CFG_LSB  = 0;
	localparam int MODE_BL_LSB   = 3;
	localparam int MODE_MUX_BIT  = 5;
	localparam int MODE_DLL_BIT  = 7;
	localparam int MODE_USED_TOP = 9;
	localparam int MODE_WIDTH    = 18;
	localparam int MUX_LOW_BITS  = 11;
	// burst size field values
	localparam logic [1:0] BL_2 = 2'h0;
	localparam logic [1:0] BL_4 = 2'h1;
	localparam logic [1:0] BL_8 = 2'h2;
	// pin widths and reset values
	localparam int ADDR_PINS = 21;
	localparam int BANK_PINS = 3;
	localparam logic [17:0] MODE_RESET = 18'h00000;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### tb/dram_dev_model.sv
// device-side model of the multi-bank dram seen through its command pins
// assumes pins change just after rising ref_clk edges; counts rule breaks
`timescale 1ns/1ps
`default_nettype none
module dram_dev_model #(
	parameter int MRS_RECOVER = 6,
	parameter int DLL_LOCK    = 16
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// command pins
	input  wire logic        select_n,
	input  wire logic        we_n,
	input  wire logic        ref_n,
	input  wire logic [20:0] addr,
	input  wire logic [2:0]  bank,
	// decoded commands for the bench
	output logic             seen,
	output logic [1:0]       code_q,
	output logic [2:0]       bank_q,
	output logic [20:0]      addr_q,
	output logic [17:0]      mode_q,
	output logic [7:0]       viol
);
	int          cyc;
	int          t0;
	int          rec_end;
	int          idle_end;
	int          dll_end;
	int          rc;
	int          free_at [8];
	int          wr_at [8];
	logic        half_ff;
	logic [10:0] low_ff;
	logic [1:0]  pcode;
	logic [2:0]  pbank;

	////////////////////////////////////////////////////////////////////////
	function automatic int row_cycles(input logic [2:0] c);
		return (c == 3'h2) ? 6 : (c == 3'h3) ? 8 : (c == 3'h4) ? 3 :
			(c == 3'h5) ? 5 : 4;
	endfunction

	task automatic complete(input logic [1:0] c, input logic [2:0] b,
		input logic [20:0] a);
		seen   <= 1'b1;
		code_q <= c;
		bank_q <= b;
		addr_q <= (c == dram_cmd_pkg::CMD_REFRESH) ? 21'h0 : a;
		if (c == dram_cmd_pkg::CMD_MODE) begin
			mode_q <= a[17:0];
			if (a[17:10] != 8'h00 || a[2:0] == 3'h0 || a[2:0] > 3'h5)
				viol = viol + 8'h01;
			if (a[4:3] == 2'h3 || (a[4:3] == 2'h2 &&
				(a[2:0] == 3'h1 || a[2:0] == 3'h4)))
				viol = viol + 8'h01;
			if (a[7] && !mode_q[7])
				dll_end = t0 + DLL_LOCK;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc = 0;
			viol = 8'h00;
			rec_end = 0;
			idle_end = 0;
			dll_end = 0;
			half_ff <= 1'b0;
			seen <= 1'b0;
			mode_q <= 18'h00000;
			for (int i = 0; i < 8; i++) begin
				free_at[i] = 0;
				wr_at[i] = -9;
			end
		end else begin
			cyc = cyc + 1;
			seen <= 1'b0;
			rc = row_cycles(mode_q[2:0]);
			if (half_ff) begin
				half_ff <= 1'b0;
				if (!select_n)
					viol = viol + 8'h01;
				complete(pcode, pbank, {addr[9:0], low_ff});
			end else if (!select_n) begin
				t0 = cyc;
				pcode = {we_n, ref_n};
				pbank = bank;
				if (pcode == dram_cmd_pkg::CMD_MODE) begin
					if (cyc < idle_end)
						viol = viol + 8'h01;
					rec_end = cyc + MRS_RECOVER;
				end else begin
					if (cyc < rec_end || cyc < free_at[bank])
						viol = viol + 8'h01;
					if (pcode == dram_cmd_pkg::CMD_READ && (cyc < dll_end ||
						(rc == 3 && cyc < wr_at[bank] + 4)))
						viol = viol + 8'h01;
					free_at[bank] = cyc + rc;
					if (pcode == dram_cmd_pkg::CMD_WRITE)
						wr_at[bank] = cyc;
					idle_end = cyc + ((pcode == dram_cmd_pkg::CMD_REFRESH) ? rc :
						rc + 1 + (1 << mode_q[4:3]));
				end
				// refresh needs no second half, so it may repeat each cycle
				if (mode_q[5] && pcode != dram_cmd_pkg::CMD_REFRESH) begin
					half_ff <= 1'b1;
					low_ff <= addr[10:0];
				end else
					complete(pcode, bank, addr);
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench: axi4-lite master, expected command queue, device model
// assumes the controller answers each axi request and drives pins on ref_clk
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	localparam int DLL_SIM = 16;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q, m_code;
	logic [31:0] s_axi_rdata;
	logic        mem_select_n, mem_we_n, mem_ref_n, m_seen;
	logic [20:0] mem_addr, m_addr;
	logic [2:0]  mem_bank_select_bits, m_bank;
	logic [17:0] m_mode;
	logic [7:0]  m_viol;
	logic [25:0] exp_q [$];
	logic [25:0] e;
	int          blc;
	int          checked;
	int          n_mismatch;
	int          cycles;

	always #2.5 ref_clk = ~ref_clk;

	dram_cmd_ctrl #(.DQ_WIDTH(9), .MRS_RECOVER(6), .DLL_LOCK(DLL_SIM))
		i_dram_cmd_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .mem_select_n(mem_select_n),
		.mem_we_n(mem_we_n), .mem_ref_n(mem_ref_n), .mem_addr(mem_addr),
		.mem_bank_select_bits(mem_bank_select_bits));

	dram_dev_model #(.MRS_RECOVER(6), .DLL_LOCK(DLL_SIM)) i_dram_dev_model (
		.ref_clk(ref_clk), .rst_n(rst_n), .select_n(mem_select_n),
		.we_n(mem_we_n), .ref_n(mem_ref_n), .addr(mem_addr),
		.bank(mem_bank_select_bits), .seen(m_seen), .code_q(m_code),
		.bank_q(m_bank), .addr_q(m_addr), .mode_q(m_mode), .viol(m_viol));

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rresp_q = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_idle();
		logic [31:0] d;
		do rd(dram_cmd_pkg::OFF_STATUS, d); while (d[0] !== 1'b0);
	endtask

	task automatic issue(input logic [1:0] c, input logic [2:0] b,
		input logic [20:0] a);
		logic [1:0]  r;
		logic [20:0] ea;
		ea = a & ((21'h1 << (21 - blc)) - 21'h1);
		if (c == dram_cmd_pkg::CMD_REFRESH)
			ea = 21'h0;
		if (c == dram_cmd_pkg::CMD_MODE)
			ea = {11'h000, a[9:0]};
		exp_q.push_back({c, b, ea});
		wr(dram_cmd_pkg::OFF_ADDR, {11'h000, a}, r);
		wr(dram_cmd_pkg::OFF_BANK, {29'h0, b}, r);
		wr(dram_cmd_pkg::OFF_CMD, {30'h0, c}, r);
		`CHK("cmd resp", dram_cmd_pkg::RESP_OKAY, r)
		wait_idle();
	endtask

	task automatic mode_set(input logic [9:0] mw);
		logic [31:0] d;
		d = $urandom();
		issue(dram_cmd_pkg::CMD_MODE, 3'h0, {d[10:0], mw});
		blc = mw[4:3];
		rd(dram_cmd_pkg::OFF_MODE, d);
		`CHK("mode word", {22'h0, mw}, d)
	endtask

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end else if (m_seen === 1'b1) begin
			`CHK("queue depth", 1'b1, exp_q.size() > 0)
			e = exp_q.pop_front();
			`CHK("command", e[25:24], m_code)
			if (m_code !== dram_cmd_pkg::CMD_MODE)
				`CHK("bank", e[23:21], m_bank)
			`CHK("address", e[20:0], m_addr)
		end
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [9:0]  mw;
		logic [2:0]  b;
		logic [20:0] a;
		logic [9:0]  bad [5] = '{10'h011, 10'h014, 10'h008, 10'h00E, 10'h019};
		blc = 0;
		void'($urandom(32'h0B49536C));
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		`CHK("idle select", 1'b1, mem_select_n)
		rd(dram_cmd_pkg::OFF_MODE, d);
		`CHK("reset mode", 32'h0, d)
		rd(8'h20, d);
		`CHK("unmapped resp", dram_cmd_pkg::RESP_OKAY, rresp_q)
		`CHK("unmapped data", 32'h0, d)
		wr(8'h20, 32'h0, r);
		`CHK("unmapped wr", dram_cmd_pkg::RESP_SLVERR, r)
		for (int c = 1; c <= 5; c++) begin
			mw = 10'(c);
			mw[4:3] = (c == 3) ? 2'h2 : 2'(c % 2);
			mw[5] = (c == 5);
			mw[7] = (c == 2);
			mode_set(mw);
			b = 3'($urandom());
			a = 21'($urandom());
			issue(dram_cmd_pkg::CMD_WRITE, b, a);
			issue(dram_cmd_pkg::CMD_READ, b, a);
			issue(dram_cmd_pkg::CMD_READ, b, 21'($urandom()));
			issue(dram_cmd_pkg::CMD_REFRESH, b, a);
			issue(dram_cmd_pkg::CMD_REFRESH, b + 3'h1, a);
		end
		// three back-to-back commands to one bank: the third meets a pending one
		mode_set(10'h00A);
		exp_q.push_back({dram_cmd_pkg::CMD_READ, 3'h5, 21'h0});
		exp_q.push_back({dram_cmd_pkg::CMD_READ, 3'h5, 21'h0});
		wr(dram_cmd_pkg::OFF_ADDR, 32'h0, r);
		wr(dram_cmd_pkg::OFF_BANK, 32'h5, r);
		for (int i = 0; i < 3; i++)
			wr(dram_cmd_pkg::OFF_CMD, {30'h0, dram_cmd_pkg::CMD_READ}, r);
		wait_idle();
		rd(dram_cmd_pkg::OFF_STATUS, d);
		`CHK("refused flag", 1'b1, d[2])
		wr(dram_cmd_pkg::OFF_STATUS, 32'h4, r);
		rd(dram_cmd_pkg::OFF_STATUS, d);
		`CHK("refused clear", 1'b0, d[2])
		foreach (bad[i]) begin
			wr(dram_cmd_pkg::OFF_ADDR, {22'h0, bad[i]}, r);
			wr(dram_cmd_pkg::OFF_CMD, 32'h0, r);
			wait_idle();
			rd(dram_cmd_pkg::OFF_STATUS, d);
			`CHK("bad mode flag", 1'b1, d[3])
			wr(dram_cmd_pkg::OFF_STATUS, 32'h8, r);
		end
		rd(dram_cmd_pkg::OFF_MODE, d);
		`CHK("mode kept", 32'h00A, d)
		repeat (4) @(posedge ref_clk);
		`CHK("device rule breaks", 8'h00, m_viol)
		`CHK("queue empty", 0, exp_q.size())
		end_of_test();
	end
endmodule
`default_nettype wire
